// ===== hdl/fpm_panel.sv
// switch board and meter panel select logic with apb status/control
// assumes synchronous button inputs; meter sample channels are digital words
// assumes the controller returns its lamp sinks in the pclk domain
// What this block does
// - each power-control press sends a command to the controller.
// - buttons other than off have a lamp lit after press.
// - meter position counter advances once per meter-select closure.
// - one counter value addresses meter mux and lamp demux together.
// - power-up clears the position counter to zero.
// - only the selected position lamp is lit.
// - each forward/reflected press toggles the selection flop.
// - the flop steers forward or reflected sample to power meter.
// - power-up sets the flop, selecting forward power.
// - two lamps show forward or reflected selection.
module fpm_panel import fpm_pkg::*; #(
  parameter int DB_CYC = DEBOUNCE_CYC,
  parameter int NPOS = NUM_POS,
  parameter int SW = 12
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [NUM_PWR_BTN-1:0] pwr_btn, // power buttons, high pressed
  output logic [NUM_PWR_BTN-1:0] pwr_cmd, // commands to controller
  input wire logic [NUM_PWR_BTN-1:0] pwr_lamp_sink, // controller sink, high lit
  output logic [NUM_PWR_BTN-1:0] pwr_lamp, // power lamps, off lamp always dark
  input wire logic meter_select_button, // meter-select button
  input wire logic fwd_refl_select_button, // fwd/refl button
  input wire logic [NPOS*SW-1:0] meter_samples, // meter channel words
  input wire logic [SW-1:0] fwd_sample, // forward power sample
  input wire logic [SW-1:0] refl_sample, // reflected power sample
  output logic [SW-1:0] meter_out, // multimeter drive
  output logic [SW-1:0] power_meter_out, // power meter drive
  output logic [NPOS-1:0] meter_lamps, // position lamps
  output logic power_meter_lamp_a, // forward lamp
  output logic power_meter_lamp_b, // reflected lamp
  output logic [POS_W-1:0] meter_position // current position
);
  // position counter and forward/reflected flop
  logic [POS_W-1:0] meter_position_counter_q;
  logic [POS_W-1:0] pos_inc;
  logic [POS_W-1:0] pos_step;
  logic [POS_W-1:0] pos_d;
  logic fwd_refl_toggle_flop_q;
  logic fwd_d;
  logic adv_press;
  logic tog_press;
  logic adv;
  logic tog;
  logic at_last;

  // power buttons and their lamps
  logic [NUM_PWR_BTN-1:0] pwr_level;
  logic [NUM_PWR_BTN-1:0] pwr_cmd_q;
  logic [NUM_PWR_BTN-1:0] pwr_lamp_q;
  logic [NUM_PWR_BTN-1:0] pwr_lamp_d;
  logic [NUM_PWR_BTN-1:0] lamp_mask;

  // meter selection
  logic [SW-1:0] chan [NPOS];
  logic [SW-1:0] meter_signal_mux;
  logic [SW-1:0] power_meter_mux;
  logic [SW-1:0] meter_out_q;
  logic [SW-1:0] power_out_q;
  logic [NPOS-1:0] lamp_dec;
  logic [NPOS-1:0] lamps_q;
  logic lamp_a_q;
  logic lamp_b_q;

  // register bus
  logic setup;
  logic acc;
  logic done;
  logic hit_ctrl;
  logic hit_stat;
  logic unmapped;
  logic wr_ctrl;
  logic rd_stat;
  logic sw_adv;
  logic sw_tog;
  logic [31:0] st_pos;
  logic [31:0] st_fwd;
  logic [31:0] st_press;
  logic [31:0] st_lamp;
  logic [31:0] status_word;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic pready_d;
  logic pready_q;
  logic pslverr_d;
  logic pslverr_q;

  // debounced level of each power button is its command
  for (genvar i = 0; i < NUM_PWR_BTN; i++) begin : g_pwr
    fpm_debounce #(.CNT_MAX(DB_CYC)) u_db (
      .pclk(pclk),
      .presetn(presetn),
      .raw(pwr_btn[i]),
      .level(pwr_level[i]),
      .press()
    );
  end

  // meter-select button gives one advance pulse per press
  fpm_debounce #(.CNT_MAX(DB_CYC)) u_db_adv (
    .pclk(pclk),
    .presetn(presetn),
    .raw(meter_select_button),
    .level(),
    .press(adv_press)
  );

  // forward/reflected button gives one toggle pulse per press
  fpm_debounce #(.CNT_MAX(DB_CYC)) u_db_tog (
    .pclk(pclk),
    .presetn(presetn),
    .raw(fwd_refl_select_button),
    .level(),
    .press(tog_press)
  );

  // apb decode: a write acts only at the edge where pready is sampled high
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign done = acc && pready_q;
  assign hit_ctrl = paddr == REG_CTRL;
  assign hit_stat = paddr == REG_STATUS;
  assign unmapped = !(hit_ctrl || hit_stat);
  assign wr_ctrl = done && pwrite && hit_ctrl;
  assign rd_stat = setup && !pwrite && hit_stat;
  assign sw_adv = wr_ctrl && pwdata[CTRL_SW_ADV];
  assign sw_tog = wr_ctrl && pwdata[CTRL_SW_TOG];
  assign pready_d = setup;
  assign pslverr_d = setup && unmapped;

  // a button press and a software write in one cycle give a single step
  assign adv = adv_press || sw_adv;
  assign tog = tog_press || sw_tog;
  assign at_last = meter_position_counter_q == POS_W'(NPOS - 1);
  assign pos_inc = meter_position_counter_q + POS_W'(1);
  assign pos_step = at_last ? POS_RESET : pos_inc;
  assign pos_d = adv ? pos_step : meter_position_counter_q;
  assign fwd_d = tog ? !fwd_refl_toggle_flop_q : fwd_refl_toggle_flop_q;

  // channel words unpacked so the mux picks a whole word
  for (genvar i = 0; i < NPOS; i++) begin : g_chan
    assign chan[i] = meter_samples[i*SW +: SW];
  end

  // the mux and demux both read the same counter register
  assign meter_signal_mux = chan[meter_position_counter_q];
  assign power_meter_mux = fwd_refl_toggle_flop_q ? fwd_sample : refl_sample;

  fpm_lamp_demux #(.N(NPOS)) meter_lamp_demux (
    .sel(meter_position_counter_q),
    .lamp(lamp_dec)
  );

  // off button has no lamp; lamp lights where the controller sinks it
  assign lamp_mask = ~(NUM_PWR_BTN'(1) << PWR_BTN_OFF);
  assign pwr_lamp_d = pwr_lamp_sink & lamp_mask;

  // status word fields
  assign st_pos = 32'(meter_position_counter_q) << ST_POS_LSB;
  assign st_fwd = 32'(fwd_refl_toggle_flop_q) << ST_FWD;
  assign st_press = 32'(pwr_level) << ST_PRESS_LSB;
  assign st_lamp = 32'(lamp_dec) << ST_LAMP_LSB;
  assign status_word = st_pos | st_fwd | st_press | st_lamp;
  // read data is taken in the setup cycle so that it stands with pready
  assign rdata_d = rd_stat ? status_word : 32'h0000_0000;

  // position counter: cleared at power-up, one step per press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meter_position_counter_q <= POS_RESET;
    end else begin
      meter_position_counter_q <= pos_d;
    end
  end

  // forward/reflected flop: set at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_refl_toggle_flop_q <= FWD_RESET;
    end else begin
      fwd_refl_toggle_flop_q <= fwd_d;
    end
  end

  // commands to the controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cmd_q <= '0;
    end else begin
      pwr_cmd_q <= pwr_level;
    end
  end

  // power lamps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_lamp_q <= '0;
    end else begin
      pwr_lamp_q <= pwr_lamp_d;
    end
  end

  // multimeter drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meter_out_q <= '0;
    end else begin
      meter_out_q <= meter_signal_mux;
    end
  end

  // power meter drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_out_q <= '0;
    end else begin
      power_out_q <= power_meter_mux;
    end
  end

  // position lamps start with the first position lit
  for (genvar i = 0; i < NPOS; i++) begin : g_lamp_q
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lamps_q[i] <= (i == int'(POS_RESET));
      end else begin
        lamps_q[i] <= lamp_dec[i];
      end
    end
  end

  // forward lamp follows the flop from power-up on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_a_q <= FWD_RESET;
    end else begin
      lamp_a_q <= fwd_refl_toggle_flop_q;
    end
  end

  // reflected lamp is the inverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_b_q <= !FWD_RESET;
    end else begin
      lamp_b_q <= !fwd_refl_toggle_flop_q;
    end
  end

  // apb: zero wait states, answer in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= rdata_d;
    end
  end

  // pready stands for the first access cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  // error flags an unmapped address together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwr_cmd = pwr_cmd_q;
  assign pwr_lamp = pwr_lamp_q;
  assign meter_out = meter_out_q;
  assign power_meter_out = power_out_q;
  assign meter_lamps = lamps_q;
  assign power_meter_lamp_a = lamp_a_q;
  assign power_meter_lamp_b = lamp_b_q;
  assign meter_position = meter_position_counter_q;
endmodule

// ===== hdl/fpm_pkg.sv
// package for the front panel meter select block
// assumes one 100 MHz clock; button inputs are synchronous raw contacts
package fpm_pkg;
  localparam int CLK_HZ = 100_000_000;
  // debounce settle time in microseconds
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  // number of power-control buttons: off, low, med, high, raise, lower
  localparam int NUM_PWR_BTN = 6;
  localparam int PWR_BTN_OFF = 0;
  // number of multimeter positions used
  localparam int NUM_POS = 6;
  localparam int POS_W = 3;
  localparam logic [POS_W-1:0] POS_RESET = 3'h0;
  // toggle flop reset state: 1 means forward power
  localparam logic FWD_RESET = 1'b1;

  // apb register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CTRL_SW_ADV = 0;
  localparam int CTRL_SW_TOG = 1;
  localparam int ST_POS_LSB = 0;
  localparam int ST_FWD = 4;
  localparam int ST_PRESS_LSB = 8;
  localparam int ST_LAMP_LSB = 16;
endpackage

// ===== hdl/fpm_debounce.sv
// debounces one pushbutton and emits a single pulse per press
// assumes the raw contact is already synchronous to pclk
module fpm_debounce import fpm_pkg::*; #(
  parameter int CNT_MAX = DEBOUNCE_CYC
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic raw, // raw contact, high while pressed
  output logic level, // debounced level
  output logic press // one-cycle pulse on press
);
  localparam int CW = $clog2(CNT_MAX + 1);
  logic [CW-1:0] cnt_q;
  logic level_q;
  logic press_q;
  wire differs = raw != level_q;
  wire settled = cnt_q == CW'(CNT_MAX - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
      press_q <= 1'b0;
    end else begin
      press_q <= differs && settled && raw;
      if (!differs) begin
        cnt_q <= '0;
      end else if (settled) begin
        cnt_q <= '0;
        level_q <= raw;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign level = level_q;
  assign press = press_q;
endmodule

// ===== hdl/fpm_lamp_demux.sv
// one-hot decode of the meter position to its lamp
// assumes position values below N
module fpm_lamp_demux import fpm_pkg::*; #(
  parameter int N = NUM_POS
) (
  input wire logic [POS_W-1:0] sel, // selected position
  output logic [N-1:0] lamp // one lamp per position, high lit
);
  for (genvar i = 0; i < N; i++) begin : g_lamp
    assign lamp[i] = sel == POS_W'(i);
  end
endmodule

// ===== verification/fpm_ctrl_model.sv
// controller model that sinks the power lamps
// assumes pwr_cmd levels from the panel in the pclk domain
module fpm_ctrl_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic [5:0] pwr_cmd, // panel commands
  output logic [5:0] pwr_lamp_sink // sink, high lit
);
  timeunit 1ns;
  timeprecision 100ps;
  // keeps the lamp of the last commanded button lit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pwr_lamp_sink <= 6'h00;
    else if (pwr_cmd != 6'h00) pwr_lamp_sink <= pwr_cmd;
  end
endmodule

// ===== verification/fpm_panel_assertions.sv
// port checker for the panel
// assumes one pclk domain, async active-low presetn
module fpm_panel_chk import fpm_pkg::*; #(
  parameter int NPOS = NUM_POS,
  parameter int SW = 12
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pready, // apb
  input wire logic [NUM_PWR_BTN-1:0] pwr_btn, // buttons
  input wire logic [NUM_PWR_BTN-1:0] pwr_cmd, // commands
  input wire logic [NUM_PWR_BTN-1:0] pwr_lamp_sink, // sinks
  input wire logic [NUM_PWR_BTN-1:0] pwr_lamp, // lamps
  input wire logic [NPOS*SW-1:0] meter_samples, // channels
  input wire logic [SW-1:0] meter_out, // meter
  input wire logic [NPOS-1:0] meter_lamps, // position lamps
  input wire logic power_meter_lamp_a, // forward
  input wire logic power_meter_lamp_b, // reflected
  input wire logic [POS_W-1:0] meter_position // position
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [SW-1:0] ch;
  assign ch = meter_samples[meter_position*SW +: SW];
  sequence apb_setup;
    psel && !penable;
  endsequence
  a_apb_zero_wait: assert property (apb_setup ##1 psel && penable |-> pready) else $error("late pready");
  a_off_dark: assert property (!pwr_lamp[0]) else $error("off lamp lit");
  a_lamp_follow: assert property ($past(presetn) |-> pwr_lamp == ($past(pwr_lamp_sink) & 6'h3e))
    else $error("lamp not from sink");
  a_pos_onehot: assert property ($past(presetn) |-> meter_lamps == (NPOS'(1) << $past(meter_position)))
    else $error("lamp not one-hot");
  a_mux_follow: assert property ($past(presetn) |-> meter_out == $past(ch)) else $error("meter mux");
  a_pos_step: assert property (meter_position != $past(meter_position) |-> meter_position ==
    ($past(meter_position) == POS_W'(NPOS-1) ? 3'h0 : $past(meter_position) + 3'h1)) else $error("bad step");
  a_pos_range: assert property (meter_position < NPOS) else $error("position range");
  a_fwd_lamps: assert property ($past(presetn) |-> power_meter_lamp_b != power_meter_lamp_a)
    else $error("fwd lamps");
  a_cmd_held: assert property (((pwr_cmd & ~$past(pwr_cmd)) & ~$past(pwr_btn, 2)) == 6'h00)
    else $error("cmd without press");
  a_reset_fwd: assert property ($rose(presetn) |=> power_meter_lamp_a && meter_position == 3'h0)
    else $error("reset state");
endmodule
bind fpm_panel fpm_panel_chk #(.NPOS(NPOS), .SW(SW)) u_fpm_panel_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pwr_btn(pwr_btn), .pwr_cmd(pwr_cmd),
  .pwr_lamp_sink(pwr_lamp_sink), .pwr_lamp(pwr_lamp), .meter_samples(meter_samples), .meter_out(meter_out),
  .meter_lamps(meter_lamps), .power_meter_lamp_a(power_meter_lamp_a), .power_meter_lamp_b(power_meter_lamp_b),
  .meter_position(meter_position));

// ===== verification/tb_top.sv
// testbench for the panel: buttons, apb and controller model
// assumes debounce shortened to DB cycles
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fpm_pkg::*;
  localparam int DB = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, la, lb;
  logic [11:0] paddr = 0, fwd = 12'h0a5, refl = 12'h05a, mo, pmo;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] btns = 0;
  logic [5:0] cmd, sink, plamp, held, lamps;
  logic [71:0] smp;
  logic [2:0] pos;
  int n_mismatch = 0, checks = 0;
  fpm_panel #(.DB_CYC(DB)) u_fpm_panel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwr_btn(btns[7:2]), .pwr_cmd(cmd), .pwr_lamp_sink(sink), .pwr_lamp(plamp), .meter_select_button(btns[0]),
    .fwd_refl_select_button(btns[1]), .meter_samples(smp), .fwd_sample(fwd), .refl_sample(refl),
    .meter_out(mo), .power_meter_out(pmo), .meter_lamps(lamps), .power_meter_lamp_a(la),
    .power_meter_lamp_b(lb), .meter_position(pos));
  fpm_ctrl_model u_fpm_ctrl_model (.pclk(pclk), .presetn(presetn), .pwr_cmd(cmd), .pwr_lamp_sink(sink));
  initial forever #5 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask
  // holds button b for hold+1 cycles, records commands seen while held
  task automatic press(input int b, input int hold);
    @(posedge pclk);
    btns[b] <= 1'b1;
    repeat (hold) @(posedge pclk);
    @(negedge pclk);
    held = cmd;
    @(posedge pclk);
    btns[b] <= 1'b0;
    repeat (12) @(negedge pclk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 6; i++) smp[i*12 +: 12] = 12'h100 + 12'(i);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    check(pos, 0);
    apb(1'b0, 12'h004, 0);
    check(rd, 32'h0001_0010);
    $display("test reset done");
    for (int i = 1; i <= 6; i++) begin
      press(0, 10);
      check(pos, i % 6);
      check(lamps, 6'h01 << (i % 6));
      check(mo, 12'h100 + i % 6);
    end
    press(0, 2);
    check(pos, 0);
    $display("test meter select done");
    press(1, 10);
    check({la, lb, pmo}, {2'b01, refl});
    apb(1'b1, 12'h000, 32'h0000_0002);
    check({la, lb, pmo}, {2'b10, fwd});
    $display("test fwd refl done");
    for (int i = 0; i < 6; i++) begin
      press(i + 2, 10);
      check(held, 6'h01 << i);
      check(plamp, (6'h01 << i) & 6'h3e);
    end
    $display("test power buttons done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    check(pos, 1);
    apb(1'b0, 12'h000, 0);
    check(rd, 0);
    apb(1'b1, 12'h008, 32'h0000_0003);
    check({err, pos}, 4'h9);
    apb(1'b0, 12'h008, 0);
    check(err, 1);
    check(rd, 0);
    $display("test apb done");
    complete_run;
  end
  initial begin
    #50us;
    n_mismatch++;
    complete_run;
  end
endmodule
